// File: opr_pkg.sv
// Constants for the output PWM gating and overcurrent recovery control block.
package opr_pkg;

    localparam int NUM_OUT = 10;
    localparam logic [4:0] ADDR_RECOV_HB_PWM = 5'h02;
    localparam logic [4:0] ADDR_HS_PWM_SENSE = 5'h03;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // Writable bits of the first register, without and with the EC variant.
    localparam logic [15:0] MASK_RECOV_HB_BASE = 16'he5e4;
    localparam logic [15:0] MASK_RECOV_HB_EC = 16'he7e7;

    // First register fields.
    localparam int B_OCR1 = 15;
    localparam int B_OCR2 = 14;
    localparam int B_OCR3 = 13;
    localparam int B_OCR4 = 10;
    localparam int B_OCR_EC = 9;
    localparam int B_INT_PWM_EN = 8;
    localparam int B_SEL_OUT1 = 7;
    localparam int B_SEL_OUT2 = 6;
    localparam int B_SEL_OUT3 = 5;
    localparam int B_SEL_OUT4 = 2;
    localparam int B_DAC_FULL = 0;

    // Second register fields.
    localparam int B_OCR5 = 15;
    localparam int B_OCR9 = 11;
    localparam int B_SEL_OUT5 = 10;
    localparam int B_SEL_OUT9 = 6;
    localparam int B_RATE_SEL = 5;
    localparam int B_SUPPLY_DIS = 4;
    localparam int B_SENSE_HI = 3;
    localparam int B_SENSE_LO = 0;

    // Reference level codes: 1.2 V of a 1.5 V / 64 step scale is code 51.
    localparam logic [5:0] DAC_CLAMP_CODE = 6'h33;

    // Recovery delays, in microseconds, at a 50 ns core clock.
    localparam int CLK_PERIOD_NS = 50;
    localparam int SLOW_RECOV_US = 200;
    localparam int FAST_RECOV_US = 50;
    localparam int BULB_RECOV_US = 100;
    localparam int SLOW_RECOV_CYC = SLOW_RECOV_US * 1000 / CLK_PERIOD_NS;
    localparam int FAST_RECOV_CYC = FAST_RECOV_US * 1000 / CLK_PERIOD_NS;
    localparam int BULB_RECOV_CYC = BULB_RECOV_US * 1000 / CLK_PERIOD_NS;
    localparam int DLY_W = 12;

endpackage

// File: opr_recovery_chan.sv
// One output's overcurrent flag, shutdown and automatic recovery timer.
`timescale 1ns/1ps
`default_nettype none
module opr_recovery_chan
    import opr_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic oc_event_i,
    input wire logic flag_clr_i,
    input wire logic recovery_en_i,
    input wire logic [DLY_W-1:0] delay_cyc_i,
    output logic flag_o,
    output logic tripped_o
);

    typedef enum logic [1:0] {ST_RUN, ST_OFF, ST_WAIT} opr_chan_state_t;

    opr_chan_state_t state_q, state_d;
    logic [DLY_W-1:0] cnt_q, cnt_d;
    logic flag_q, flag_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        // A new event wins over a clear in the same cycle.
        flag_d = oc_event_i | (flag_q & ~flag_clr_i);
        case (state_q)
            ST_RUN: begin
                if (oc_event_i) begin
                    state_d = recovery_en_i ? ST_WAIT : ST_OFF;
                    cnt_d = '0;
                end
            end
            ST_OFF: begin
                if (recovery_en_i && !oc_event_i) begin
                    state_d = ST_WAIT;
                    cnt_d = '0;
                end else if (flag_clr_i && !oc_event_i) begin
                    state_d = ST_RUN;
                end
            end
            ST_WAIT: begin
                if (oc_event_i) begin
                    cnt_d = '0;
                end else if (!recovery_en_i) begin
                    state_d = ST_OFF;
                end else if (cnt_q >= delay_cyc_i - 12'h001) begin
                    state_d = ST_RUN;
                end else begin
                    cnt_d = cnt_q + 12'h001;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= ST_RUN;
            cnt_q <= '0;
            flag_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;
    assign tripped_o = (state_q != ST_RUN);

endmodule // opr_recovery_chan
`default_nettype wire

// File: opr_ctrl.sv
// Control registers for overcurrent recovery, PWM gating and DAC range.
`timescale 1ns/1ps
`default_nettype none
module opr_ctrl
    import opr_pkg::*;
#(
    parameter bit EC_VARIANT = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic reg_we_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    input wire logic pwm_input_a_i,
    input wire logic pwm_input_b_i,
    input wire logic [3:0] int_pwm_i,
    input wire logic [NUM_OUT-1:0] drive_req_i,
    input wire logic [1:0] bulb_mode_i,
    input wire logic [5:0] dac_code_i,
    input wire logic [NUM_OUT-1:0] oc_event_i,
    input wire logic [NUM_OUT-1:0] overcurrent_flag_clr_i,
    input wire logic global_fault_clr_i,
    output logic [NUM_OUT-1:0] overcurrent_flag_o,
    output logic global_fault_flag_o,
    output logic [NUM_OUT-1:0] out_on_o,
    output logic internal_pwm_en_o,
    output logic supply_fault_recovery_dis_o,
    output logic [3:0] sense_mux_select_o,
    output logic [5:0] dac_level_o
);

    ////////////////////////////////////////////////////////////////////////
    // Register file.

    logic [15:0] recov_hb_q, recov_hb_d;
    logic [15:0] hs_sense_q, hs_sense_d;
    logic [15:0] rdata_q, rdata_d;
    logic [15:0] wmask;

    assign wmask = EC_VARIANT ? MASK_RECOV_HB_EC : MASK_RECOV_HB_BASE;

    always_comb begin
        recov_hb_d = recov_hb_q;
        hs_sense_d = hs_sense_q;
        if (reg_we_i && reg_addr_i == ADDR_RECOV_HB_PWM) begin
            recov_hb_d = reg_wdata_i & wmask;
        end
        if (reg_we_i && reg_addr_i == ADDR_HS_PWM_SENSE) begin
            hs_sense_d = reg_wdata_i;
        end
        case (reg_addr_i)
            ADDR_RECOV_HB_PWM: rdata_d = recov_hb_q & wmask;
            ADDR_HS_PWM_SENSE: rdata_d = hs_sense_q;
            default: rdata_d = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            recov_hb_q <= REG_RESET;
            hs_sense_q <= REG_RESET;
            rdata_q <= 16'h0000;
        end else begin
            recov_hb_q <= recov_hb_d;
            hs_sense_q <= hs_sense_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Field decode.

    logic [NUM_OUT-1:0] recov_en;
    logic [NUM_OUT-1:0] pwm_sel;
    logic int_pwm_en;
    logic rate_fast;
    logic dac_full;

    always_comb begin
        recov_en[0] = recov_hb_q[B_OCR1];
        recov_en[1] = recov_hb_q[B_OCR2];
        recov_en[2] = recov_hb_q[B_OCR3];
        recov_en[3] = recov_hb_q[B_OCR4];
        recov_en[9] = EC_VARIANT & recov_hb_q[B_OCR_EC];
        pwm_sel[0] = recov_hb_q[B_SEL_OUT1];
        pwm_sel[1] = recov_hb_q[B_SEL_OUT2];
        pwm_sel[2] = recov_hb_q[B_SEL_OUT3];
        pwm_sel[3] = recov_hb_q[B_SEL_OUT4];
        pwm_sel[9] = 1'b0;
        // Output 5 holds the top bit of each field; later outputs go down.
        for (int k = 0; k <= B_OCR5 - B_OCR9; k++) begin
            recov_en[4 + k] = hs_sense_q[B_OCR5 - k];
            pwm_sel[4 + k] = hs_sense_q[B_SEL_OUT5 - k];
        end
    end

    assign int_pwm_en = recov_hb_q[B_INT_PWM_EN];
    assign rate_fast = hs_sense_q[B_RATE_SEL];
    assign dac_full = EC_VARIANT & recov_hb_q[B_DAC_FULL];

    ////////////////////////////////////////////////////////////////////////
    // PWM pin synchronisers.

    logic [1:0] pwm_a_sync_q, pwm_b_sync_q;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwm_a_sync_q <= 2'b00;
            pwm_b_sync_q <= 2'b00;
        end else begin
            pwm_a_sync_q <= {pwm_a_sync_q[0], pwm_input_a_i};
            pwm_b_sync_q <= {pwm_b_sync_q[0], pwm_input_b_i};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gating source per output.

    logic pwm_a;
    logic pwm_b;
    logic [NUM_OUT-1:0] pwm_level;

    assign pwm_a = pwm_a_sync_q[1];
    assign pwm_b = pwm_b_sync_q[1];

    always_comb begin
        pwm_level = '1;
        pwm_level[3:0] = {4{pwm_a}};
        pwm_level[4] = pwm_a;
        pwm_level[5] = pwm_b;
        pwm_level[6] = pwm_a;
        pwm_level[7] = pwm_b;
        pwm_level[8] = pwm_a;
        // While the internal unit runs, it takes over outputs 5 to 8.
        if (int_pwm_en) begin
            pwm_level[7:4] = int_pwm_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Overcurrent recovery channels.

    logic [NUM_OUT-1:0] flag;
    logic [NUM_OUT-1:0] tripped;
    logic [DLY_W-1:0] rate_dly;

    assign rate_dly = rate_fast ? DLY_W'(FAST_RECOV_CYC)
                                : DLY_W'(SLOW_RECOV_CYC);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_chan
            logic [DLY_W-1:0] dly;
            if (gi == 4 || gi == 5) begin : g_lamp
                assign dly = bulb_mode_i[gi-4] ? DLY_W'(BULB_RECOV_CYC)
                                               : rate_dly;
            end else begin : g_other
                assign dly = rate_dly;
            end
            opr_recovery_chan u_chan (
                .core_clk_i(core_clk_i),
                .rstn_i(rstn_i),
                .oc_event_i(oc_event_i[gi]),
                .flag_clr_i(overcurrent_flag_clr_i[gi]),
                .recovery_en_i(recov_en[gi]),
                .delay_cyc_i(dly),
                .flag_o(flag[gi]),
                .tripped_o(tripped[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Output drive, global fault and reference level.

    logic [NUM_OUT-1:0] out_on_q, out_on_d;
    logic glob_q, glob_d;
    logic [5:0] dac_q, dac_d;

    always_comb begin
        // An active output is switched off while tripped.
        out_on_d = drive_req_i & ~tripped
                 & (~pwm_sel | pwm_level);
        glob_d = (|oc_event_i) | (glob_q & ~global_fault_clr_i);
        if (!EC_VARIANT) begin
            dac_d = 6'h00;
        end else if (!dac_full && dac_code_i > DAC_CLAMP_CODE) begin
            dac_d = DAC_CLAMP_CODE;
        end else begin
            dac_d = dac_code_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_on_q <= '0;
            glob_q <= 1'b0;
            dac_q <= 6'h00;
        end else begin
            out_on_q <= out_on_d;
            glob_q <= glob_d;
            dac_q <= dac_d;
        end
    end

    assign out_on_o = out_on_q;
    assign overcurrent_flag_o = flag;
    assign global_fault_flag_o = glob_q;
    assign internal_pwm_en_o = int_pwm_en;
    assign supply_fault_recovery_dis_o = hs_sense_q[B_SUPPLY_DIS];
    assign sense_mux_select_o = hs_sense_q[B_SENSE_HI:B_SENSE_LO];
    assign dac_level_o = dac_q;

endmodule // opr_ctrl
`default_nettype wire

// File: opr_pkg_unused_guard.sv
// This file holds no logic; the block's constants live in opr_pkg.sv.

// File: opr_ctrl_sva.sv
// Assertion checker for the recovery, gating and reference control block.
`timescale 1ns/1ps
`default_nettype none
module opr_ctrl_sva
    import opr_pkg::*;
#(
    parameter bit EC_VARIANT = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic reg_we_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic [NUM_OUT-1:0] drive_req_i,
    input wire logic [5:0] dac_code_i,
    input wire logic [NUM_OUT-1:0] oc_event_i,
    input wire logic [NUM_OUT-1:0] overcurrent_flag_o,
    input wire logic global_fault_flag_o,
    input wire logic [NUM_OUT-1:0] out_on_o,
    input wire logic internal_pwm_en_o,
    input wire logic [5:0] dac_level_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////////////////////////////////////
    // Shadow of the full-range bit, used to predict the reference code.
    logic full_q;
    logic full_d;
    logic [5:0] dac_exp;
    logic [15:0] mask;
    assign mask = EC_VARIANT ? MASK_RECOV_HB_EC : MASK_RECOV_HB_BASE;
    always_comb begin
        full_d = full_q;
        if (reg_we_i && reg_addr_i == ADDR_RECOV_HB_PWM) begin
            full_d = reg_wdata_i[B_DAC_FULL];
        end
        dac_exp = dac_code_i;
        if (!full_q && dac_code_i > DAC_CLAMP_CODE) begin
            dac_exp = DAC_CLAMP_CODE;
        end
        if (!EC_VARIANT) begin
            dac_exp = 6'h00;
        end
    end
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            full_q <= 1'b0;
        end else begin
            full_q <= full_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_wr2;
        reg_we_i && reg_addr_i == ADDR_RECOV_HB_PWM;
    endsequence
    sequence s_wr3_read;
        reg_we_i && reg_addr_i == ADDR_HS_PWM_SENSE
            ##1 !reg_we_i && reg_addr_i == ADDR_HS_PWM_SENSE;
    endsequence
    a_oc_sets_flag: assert property ((oc_event_i != '0) |=>
        (overcurrent_flag_o & $past(oc_event_i)) == $past(oc_event_i))
        else $error("overcurrent flag not set");
    a_oc_sets_global: assert property ((oc_event_i != '0) |=>
        global_fault_flag_o) else $error("global fault flag not set");
    a_oc_output_off: assert property ((oc_event_i != '0) |-> ##2
        (out_on_o & $past(oc_event_i, 2)) == '0)
        else $error("output not switched off");
    a_int_pwm_en: assert property (s_wr2 |=>
        internal_pwm_en_o == $past(reg_wdata_i[B_INT_PWM_EN]))
        else $error("internal pwm enable wrong");
    a_unused_zero: assert property (
        (reg_addr_i == ADDR_RECOV_HB_PWM) |=>
        (reg_rdata_o & ~mask) == 16'h0000) else $error("unused bits set");
    a_reg3_readback: assert property (s_wr3_read |=>
        reg_rdata_o == $past(reg_wdata_i, 2)) else $error("readback wrong");
    a_no_drive_off: assert property (1'b1 |=>
        (out_on_o & ~$past(drive_req_i)) == '0)
        else $error("output on without drive request");
    a_dac_clamp: assert property (1'b1 |=>
        dac_level_o == $past(dac_exp)) else $error("reference code wrong");
endmodule // opr_ctrl_sva
bind opr_ctrl opr_ctrl_sva #(.EC_VARIANT(EC_VARIANT)) u_sva (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .reg_we_i(reg_we_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .drive_req_i(drive_req_i),
    .dac_code_i(dac_code_i), .oc_event_i(oc_event_i),
    .overcurrent_flag_o(overcurrent_flag_o),
    .global_fault_flag_o(global_fault_flag_o), .out_on_o(out_on_o),
    .internal_pwm_en_o(internal_pwm_en_o), .dac_level_o(dac_level_o));
`default_nettype wire

// File: opr_ctrl_tb.sv
// Self-checking testbench for the recovery, gating and reference block.
`timescale 1ns/1ps
`default_nettype none
module opr_ctrl_tb
    import opr_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic we = 1'b0;
    logic pa = 1'b0;
    logic pb = 1'b0;
    logic gclr = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [15:0] wd = 16'h0000;
    logic [3:0] ip = 4'h0;
    logic [NUM_OUT-1:0] drv = 10'h000;
    logic [NUM_OUT-1:0] oce = 10'h000;
    logic [NUM_OUT-1:0] fclr = 10'h000;
    logic [1:0] bulb = 2'h0;
    logic [5:0] code = 6'h00;
    logic [15:0] rd;
    logic [NUM_OUT-1:0] flag;
    logic [NUM_OUT-1:0] on;
    logic gf, pwe, sdis;
    logic [3:0] smux;
    logic [5:0] dac;
    int err_total = 0;
    int check_count = 0;
    always #25 clk = ~clk;
    opr_ctrl #(.EC_VARIANT(1'b1)) dut (.core_clk_i(clk), .rstn_i(rstn),
        .reg_we_i(we), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_rdata_o(rd), .pwm_input_a_i(pa), .pwm_input_b_i(pb),
        .int_pwm_i(ip), .drive_req_i(drv), .bulb_mode_i(bulb),
        .dac_code_i(code), .oc_event_i(oce), .overcurrent_flag_clr_i(fclr),
        .global_fault_clr_i(gclr), .overcurrent_flag_o(flag),
        .global_fault_flag_o(gf), .out_on_o(on), .internal_pwm_en_o(pwe),
        .supply_fault_recovery_dis_o(sdis), .sense_mux_select_o(smux),
        .dac_level_o(dac));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] got,
        input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk);
        we = 1'b1;
        addr = a;
        wd = d;
        @(negedge clk);
        we = 1'b0;
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        chk("rdata", rd, exp);
    endtask
    // Pulses one overcurrent event and times the automatic restart.
    task automatic rec(input int i, input int d);
        int n = 2;
        oce[i] = 1'b1;
        @(negedge clk);
        oce[i] = 1'b0;
        chk("flag", 16'(flag[i]), 16'h0001);
        tick(2);
        chk("out_off", 16'(on[i]), 16'h0000);
        chk("global", 16'(gf), 16'h0001);
        while (on[i] !== 1'b1 && n < d + 10) begin
            @(negedge clk);
            n++;
        end
        chk("delay_ok", 16'(n >= d && n <= d + 3), 16'h0001);
        fclr[i] = 1'b1;
        gclr = 1'b1;
        @(negedge clk);
        fclr[i] = 1'b0;
        gclr = 1'b0;
    endtask
    task automatic t_regs;
        rdchk(ADDR_RECOV_HB_PWM, REG_RESET);
        rdchk(ADDR_HS_PWM_SENSE, REG_RESET);
        wr(ADDR_RECOV_HB_PWM, 16'hffff);
        rdchk(ADDR_RECOV_HB_PWM, MASK_RECOV_HB_EC);
        chk("pwm_en", 16'(pwe), 16'h0001);
        wr(ADDR_HS_PWM_SENSE, 16'ha5d3);
        wr(5'h05, 16'hffff);
        rdchk(5'h05, 16'h0000);
        rdchk(ADDR_HS_PWM_SENSE, 16'ha5d3);
        chk("sense", 16'({sdis, smux}), 16'h0013);
        wr(ADDR_RECOV_HB_PWM, 16'h0000);
        wr(ADDR_HS_PWM_SENSE, 16'h0000);
        $display("registers test done");
    endtask
    task automatic t_hb;
        drv = 10'h00f;
        wr(ADDR_RECOV_HB_PWM, 16'h0080);
        pb = 1'b1;
        tick(4);
        chk("hb_b", 16'(on[3:0]), 16'h000e);
        pa = 1'b1;
        tick(4);
        chk("hb_a", 16'(on[3:0]), 16'h000f);
        pa = 1'b0;
        wr(ADDR_RECOV_HB_PWM, 16'h00e4);
        tick(4);
        chk("hb_all", 16'(on[3:0]), 16'h0000);
        wr(ADDR_RECOV_HB_PWM, 16'h0000);
        $display("half-bridge test done");
    endtask
    task automatic t_hs;
        drv = 10'h1f0;
        pb = 1'b0;
        pa = 1'b0;
        wr(ADDR_HS_PWM_SENSE, 16'h0400);
        tick(4);
        chk("hs_one", 16'(on[8:4]), 16'h001e);
        pa = 1'b1;
        wr(ADDR_HS_PWM_SENSE, 16'h07c0);
        tick(4);
        chk("hs_a", 16'(on[8:4]), 16'h0015);
        pa = 1'b0;
        pb = 1'b1;
        tick(4);
        chk("hs_b", 16'(on[8:4]), 16'h000a);
        pb = 1'b0;
        ip = 4'h5;
        wr(ADDR_RECOV_HB_PWM, 16'h0100);
        tick(4);
        chk("hs_int", 16'(on[8:4]), 16'h0005);
        pa = 1'b1;
        ip = 4'ha;
        tick(4);
        chk("hs_mix", 16'(on[8:4]), 16'h001a);
        wr(ADDR_RECOV_HB_PWM, 16'h0000);
        wr(ADDR_HS_PWM_SENSE, 16'h0000);
        $display("high-side test done");
    endtask
    task automatic t_dac;
        code = 6'h3f;
        tick(2);
        chk("dac_clamp", 16'(dac), 16'h0033);
        code = 6'h20;
        tick(2);
        chk("dac_low", 16'(dac), 16'h0020);
        code = 6'h3f;
        wr(ADDR_RECOV_HB_PWM, 16'h0001);
        tick(2);
        chk("dac_full", 16'(dac), 16'h003f);
        $display("reference test done");
    endtask
    task automatic t_oc;
        drv = 10'h011;
        wr(ADDR_RECOV_HB_PWM, 16'h8000);
        wr(ADDR_HS_PWM_SENSE, 16'h8020);
        tick(2);
        rec(0, FAST_RECOV_CYC);
        bulb = 2'h1;
        rec(4, BULB_RECOV_CYC);
        wr(ADDR_HS_PWM_SENSE, 16'h8000);
        rec(0, SLOW_RECOV_CYC);
        wr(ADDR_RECOV_HB_PWM, 16'h0000);
        oce[0] = 1'b1;
        tick(1);
        oce[0] = 1'b0;
        tick(5000);
        chk("no_recov", 16'(on[0]), 16'h0000);
        fclr[0] = 1'b1;
        tick(1);
        fclr[0] = 1'b0;
        tick(3);
        chk("released", 16'(on[0]), 16'h0001);
        $display("overcurrent test done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        err_total++;
        give_verdict();
    end
    initial begin
        tick(2);
        rstn = 1'b1;
        t_regs();
        t_hb();
        t_hs();
        t_dac();
        t_oc();
        give_verdict();
    end
endmodule // opr_ctrl_tb
`default_nettype wire
